// file: logic/clock_source_defs.svh
// Register offsets, field positions, reset values and timing counts of the clock source control
`ifndef CLOCK_SOURCE_DEFS_SVH
`define CLOCK_SOURCE_DEFS_SVH

`define CSRC_ADDR_W            12
`define CSRC_OSC_CTRL_OFS      12'h000
`define CSRC_SYS_CLK_CTRL_OFS  12'h004
`define CSRC_STATUS_OFS        12'h008

`define CSRC_MAIN_STOP_BIT     7
`define CSRC_SUB_STOP_BIT      6
`define CSRC_FAST_STOP_BIT     0
`define CSRC_EXT_MODE_BIT      6
`define CSRC_HS_ACTIVE_BIT     5
`define CSRC_MAIN_SEL_BIT      4
`define CSRC_OPT_WDT_EN_BIT    4
`define CSRC_OPT_STBY_RUN_BIT  0

`define CSRC_MAIN_STOP_RST     1'b1
`define CSRC_SUB_STOP_RST      1'b1
`define CSRC_FAST_STOP_RST     1'b0
`define CSRC_MAIN_SEL_RST      1'b0
`define CSRC_EXT_MODE_RST      1'b0

`define CSRC_CLK_PERIOD_NS     50
`define CSRC_SWITCH_GAP_NS     100
`define CSRC_SWITCH_GAP_CYC \
  ((`CSRC_SWITCH_GAP_NS + `CSRC_CLK_PERIOD_NS - 1) / `CSRC_CLK_PERIOD_NS)

`endif

// file: logic/clock_source_pkg.sv
// Types shared by the clock source control
package clock_source_pkg;

  typedef enum logic [1:0] {
    SRC_INT,
    SRC_GAP_TO_HS,
    SRC_HS,
    SRC_GAP_TO_INT
  } cpu_src_state_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  typedef struct packed {
    logic main_osc_en;
    logic ext_clk_en;
    logic fast_int_osc_en;
    logic sub_osc_en;
    logic low_speed_osc_en;
    logic watchdog_run;
  } osc_enables_t;

endpackage : clock_source_pkg

// file: logic/level_sync.sv
// Two flip-flop synchroniser for asynchronous levels
`timescale 1ns/1ps
module level_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_sys_i,
  input  wire logic             nrst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_t;

  sync_state_t state_q;
  sync_state_t state_d;

  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("level_sync width must be at least one");
    end
  endgenerate

  // First stage feeds only the second stage
  always_comb begin
    state_d        = state_q;
    state_d.meta   = async_i;
    state_d.stable = state_q.meta;
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign sync_o = state_q.stable;

endmodule : level_sync

// file: logic/system_clock_source_control.sv
// Oscillator start/stop, CPU clock source selection and APB registers
//
// Design decisions made here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "clock_source_defs.svh"

module system_clock_source_control #(
  parameter int SWITCH_GAP = `CSRC_SWITCH_GAP_CYC
) (
  input  wire logic                          clk_sys_i,
  input  wire logic                          nrst_i,
  input  wire clock_source_pkg::apb_req_t    apb_req_i,
  output clock_source_pkg::apb_rsp_t         apb_rsp_o,
  input  wire logic                          stop_mode_i,
  input  wire logic                          halt_mode_i,
  input  wire logic [7:0]                    option_byte_i,
  input  wire logic                          main_osc_ready_i,
  input  wire logic                          fast_int_osc_ready_i,
  input  wire logic                          sub_osc_ready_i,
  output clock_source_pkg::osc_enables_t     osc_en_o,
  output logic                               cpu_src_int_o,
  output logic                               cpu_src_hs_o
);

  generate
    if (SWITCH_GAP < 1 || SWITCH_GAP > 255) begin : g_bad_gap
      $error("SWITCH_GAP must lie between 1 and 255");
    end
  endgenerate

  typedef struct packed {
    logic                            main_osc_stop;
    logic                            sub_osc_stop;
    logic                            fast_internal_osc_stop;
    logic                            main_clock_select;
    logic                            ext_clock_mode;
    logic                            opt_loaded;
    logic                            watchdog_enable_option;
    logic                            watchdog_standby_run;
    clock_source_pkg::cpu_src_state_t src;
    logic [7:0]                      gap_cnt;
    clock_source_pkg::osc_enables_t  osc_en;
    logic [31:0]                     rdata;
    logic                            slverr;
  } ctrl_state_t;

  ctrl_state_t state_q;
  ctrl_state_t state_d;

  logic [2:0] ready_sync;
  logic       main_ready_s;
  logic       fast_ready_s;
  logic       sub_ready_s;
  logic       hs_ready;
  logic       int_ready;
  logic       setup_ph;
  logic       access_wr;
  logic       addr_hit;
  logic [7:0] osc_ctrl_rd;
  logic [7:0] sys_clk_rd;
  logic [7:0] status_rd;

  // Oscillator ready flags come from analog cells on other domains
  level_sync #(
    .WIDTH (3)
  ) u_ready_sync (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .async_i   ({main_osc_ready_i, fast_int_osc_ready_i, sub_osc_ready_i}),
    .sync_o    (ready_sync)
  );

  assign main_ready_s = ready_sync[2];
  assign fast_ready_s = ready_sync[1];
  assign sub_ready_s  = ready_sync[0];

  // External input has no ready flag; it counts as ready once ungated
  assign hs_ready  = state_q.ext_clock_mode ? state_q.osc_en.ext_clk_en
                                            : (state_q.osc_en.main_osc_en & main_ready_s);
  assign int_ready = state_q.osc_en.fast_int_osc_en & fast_ready_s;

  assign setup_ph  = apb_req_i.psel & ~apb_req_i.penable;
  assign access_wr = apb_req_i.psel & apb_req_i.penable & apb_req_i.pwrite;
  assign addr_hit  = (apb_req_i.paddr == `CSRC_OSC_CTRL_OFS)
                   | (apb_req_i.paddr == `CSRC_SYS_CLK_CTRL_OFS)
                   | (apb_req_i.paddr == `CSRC_STATUS_OFS);

  always_comb begin
    osc_ctrl_rd                          = 8'h00;
    osc_ctrl_rd[`CSRC_MAIN_STOP_BIT]     = state_q.main_osc_stop;
    osc_ctrl_rd[`CSRC_SUB_STOP_BIT]      = state_q.sub_osc_stop;
    osc_ctrl_rd[`CSRC_FAST_STOP_BIT]     = state_q.fast_internal_osc_stop;
    sys_clk_rd                           = 8'h00;
    sys_clk_rd[`CSRC_EXT_MODE_BIT]       = state_q.ext_clock_mode;
    sys_clk_rd[`CSRC_HS_ACTIVE_BIT]      = (state_q.src == clock_source_pkg::SRC_HS);
    sys_clk_rd[`CSRC_MAIN_SEL_BIT]       = state_q.main_clock_select;
    status_rd = {state_q.osc_en.watchdog_run, state_q.watchdog_enable_option,
                 state_q.watchdog_standby_run, hs_ready, int_ready,
                 main_ready_s, fast_ready_s, sub_ready_s};
  end

  always_comb begin
    state_d = state_q;

    // Option byte comes from flash; caught once after reset release
    if (!state_q.opt_loaded) begin
      state_d.opt_loaded             = 1'b1;
      state_d.watchdog_enable_option = option_byte_i[`CSRC_OPT_WDT_EN_BIT];
      state_d.watchdog_standby_run   = option_byte_i[`CSRC_OPT_STBY_RUN_BIT];
    end

    // Register writes take effect in the access phase
    if (access_wr) begin
      case (apb_req_i.paddr)
        `CSRC_OSC_CTRL_OFS: begin
          state_d.main_osc_stop          = apb_req_i.pwdata[`CSRC_MAIN_STOP_BIT];
          state_d.sub_osc_stop           = apb_req_i.pwdata[`CSRC_SUB_STOP_BIT];
          state_d.fast_internal_osc_stop = apb_req_i.pwdata[`CSRC_FAST_STOP_BIT];
        end
        `CSRC_SYS_CLK_CTRL_OFS: begin
          state_d.main_clock_select = apb_req_i.pwdata[`CSRC_MAIN_SEL_BIT];
          state_d.ext_clock_mode    = apb_req_i.pwdata[`CSRC_EXT_MODE_BIT];
        end
        default: begin
        end
      endcase
    end

    // Read data and error latched in setup, presented in access
    if (setup_ph) begin
      state_d.slverr = ~addr_hit;
      case (apb_req_i.paddr)
        `CSRC_OSC_CTRL_OFS:     state_d.rdata = {24'h000000, osc_ctrl_rd};
        `CSRC_SYS_CLK_CTRL_OFS: state_d.rdata = {24'h000000, sys_clk_rd};
        `CSRC_STATUS_OFS:       state_d.rdata = {24'h000000, status_rd};
        default:                state_d.rdata = 32'h00000000;
      endcase
    end

    // Oscillator enables
    state_d.osc_en.main_osc_en = ~state_q.ext_clock_mode & ~state_q.main_osc_stop
                               & ~stop_mode_i;
    state_d.osc_en.ext_clk_en = state_q.ext_clock_mode & ~state_q.main_osc_stop
                              & ~stop_mode_i;
    state_d.osc_en.fast_int_osc_en = ~state_q.fast_internal_osc_stop & ~stop_mode_i;
    state_d.osc_en.sub_osc_en = ~state_q.sub_osc_stop;
    state_d.osc_en.watchdog_run = state_q.opt_loaded & state_q.watchdog_enable_option
      & ~((halt_mode_i | stop_mode_i) & ~state_q.watchdog_standby_run);
    // Low-speed oscillator tracks the watchdog and nothing else
    state_d.osc_en.low_speed_osc_en = state_d.osc_en.watchdog_run;

    // Break-before-make: both sources off for the gap, then new one on
    if (state_q.gap_cnt != 8'h00) begin
      state_d.gap_cnt = state_q.gap_cnt - 8'h01;
    end
    case (state_q.src)
      clock_source_pkg::SRC_INT: begin
        if (state_q.main_clock_select && hs_ready) begin
          state_d.src     = clock_source_pkg::SRC_GAP_TO_HS;
          state_d.gap_cnt = 8'(SWITCH_GAP - 1);
        end
      end
      clock_source_pkg::SRC_GAP_TO_HS: begin
        if (!hs_ready) begin
          state_d.src = clock_source_pkg::SRC_INT;
        end else if (state_q.gap_cnt == 8'h00) begin
          state_d.src = clock_source_pkg::SRC_HS;
        end
      end
      clock_source_pkg::SRC_HS: begin
        // Losing the high-speed source falls back rather than freezing the CPU
        // Deselect waits for the internal clock to run
        if ((!state_q.main_clock_select && int_ready) || !hs_ready) begin
          state_d.src     = clock_source_pkg::SRC_GAP_TO_INT;
          state_d.gap_cnt = 8'(SWITCH_GAP - 1);
        end
      end
      clock_source_pkg::SRC_GAP_TO_INT: begin
        if (state_q.gap_cnt == 8'h00) begin
          state_d.src = clock_source_pkg::SRC_INT;
        end
      end
      default: begin
        state_d.src = clock_source_pkg::SRC_INT;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q                        <= '0;
      state_q.main_osc_stop          <= `CSRC_MAIN_STOP_RST;
      state_q.sub_osc_stop           <= `CSRC_SUB_STOP_RST;
      state_q.fast_internal_osc_stop <= `CSRC_FAST_STOP_RST;
      state_q.main_clock_select      <= `CSRC_MAIN_SEL_RST;
      state_q.ext_clock_mode         <= `CSRC_EXT_MODE_RST;
      state_q.src                    <= clock_source_pkg::SRC_INT;
      state_q.osc_en.fast_int_osc_en <= 1'b1;
    end else begin
      state_q <= state_d;
    end
  end

  assign apb_rsp_o.pready  = 1'b1;
  assign apb_rsp_o.pslverr = apb_req_i.psel & apb_req_i.penable & state_q.slverr;
  assign apb_rsp_o.prdata  = state_q.rdata;
  assign osc_en_o          = state_q.osc_en;
  // CPU mux offers only internal fast and high-speed; never low-speed
  assign cpu_src_int_o     = (state_q.src == clock_source_pkg::SRC_INT);
  assign cpu_src_hs_o      = (state_q.src == clock_source_pkg::SRC_HS);

  main_stop_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (state_q.main_osc_stop || stop_mode_i) |=> !osc_en_o.main_osc_en)
    else $error("main crystal enabled while stopped");

  main_run_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    $past(!state_q.ext_clock_mode && !state_q.main_osc_stop && !stop_mode_i)
      |-> osc_en_o.main_osc_en)
    else $error("main crystal not started");

  reset_src_a: assert property (@(posedge clk_sys_i)
    $rose(nrst_i) |-> cpu_src_int_o && !cpu_src_hs_o)
    else $error("CPU not on internal clock after reset");

  fast_stop_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (state_q.fast_internal_osc_stop || stop_mode_i) |=> !osc_en_o.fast_int_osc_en)
    else $error("internal fast oscillator enabled while stopped");

  fast_run_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    $past(!state_q.fast_internal_osc_stop && !stop_mode_i) |-> osc_en_o.fast_int_osc_en)
    else $error("internal fast oscillator not started");

  ext_gate_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    osc_en_o.ext_clk_en |-> $past(!stop_mode_i && !state_q.main_osc_stop))
    else $error("external clock ungated during stop");

  ext_run_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    $past(state_q.ext_clock_mode && !state_q.main_osc_stop && !stop_mode_i)
      |-> osc_en_o.ext_clk_en)
    else $error("external clock not ungated");

  sel_follow_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (state_q.main_clock_select && hs_ready && cpu_src_int_o)
      |-> ##[1:260] (cpu_src_hs_o || !hs_ready))
    else $error("select bit not followed");

  sel_back_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (!state_q.main_clock_select && int_ready && cpu_src_hs_o) |-> ##[1:260] cpu_src_int_o)
    else $error("deselect not followed");

  sub_stop_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    osc_en_o.sub_osc_en == !$past(state_q.sub_osc_stop))
    else $error("subsystem oscillator enable wrong");

  low_speed_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    osc_en_o.low_speed_osc_en == osc_en_o.watchdog_run)
    else $error("low-speed oscillator not tied to watchdog");

  wdt_stop_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    $past(!state_q.watchdog_enable_option
          || ((halt_mode_i || stop_mode_i) && !state_q.watchdog_standby_run))
      |-> !osc_en_o.watchdog_run)
    else $error("watchdog running when it must stop");

  wdt_run_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    $past(state_q.opt_loaded && state_q.watchdog_enable_option
          && !((halt_mode_i || stop_mode_i) && !state_q.watchdog_standby_run))
      |-> osc_en_o.watchdog_run)
    else $error("watchdog stopped when it must run");

  opt_once_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    state_q.opt_loaded |=> $stable(state_q.watchdog_enable_option)
      && $stable(state_q.watchdog_standby_run))
    else $error("option bits changed after capture");

  glitch_free_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    $rose(cpu_src_hs_o) |-> $past(!cpu_src_int_o))
    else $error("no gap before high-speed source");

  gap_load_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    $rose(!cpu_src_int_o && !cpu_src_hs_o) |-> state_q.gap_cnt == 8'(SWITCH_GAP - 1))
    else $error("gap counter not loaded");

  gap_end_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    $rose(cpu_src_hs_o) |-> $past(state_q.gap_cnt == 8'h00))
    else $error("gap to high-speed cut short");

  gap_back_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    $rose(cpu_src_int_o) && $past(state_q.src == clock_source_pkg::SRC_GAP_TO_INT)
      |-> $past(state_q.gap_cnt == 8'h00))
    else $error("gap to internal cut short");

  hs_ready_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    $rose(cpu_src_hs_o) |-> $past(hs_ready))
    else $error("switched to a source not running");

  hold_hs_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (state_q.src == clock_source_pkg::SRC_HS && hs_ready && !int_ready) |=> cpu_src_hs_o)
    else $error("left high-speed for a stopped internal clock");

endmodule : system_clock_source_control

// file: test/tb_system_clock_source_control.sv
// Self-checking testbench of the clock source control
`timescale 1ns/1ps
`include "clock_source_defs.svh"
module tb_system_clock_source_control;
  localparam int GAP = 3;
  logic                           clk_sys_i   = 1'b0;
  logic                           nrst_i      = 1'b0;
  clock_source_pkg::apb_req_t     apb_req     = '0;
  clock_source_pkg::apb_rsp_t     apb_rsp;
  logic                           stop_mode   = 1'b0;
  logic                           halt_mode   = 1'b0;
  logic [7:0]                     option_byte = 8'h00;
  logic                           main_rdy    = 1'b0;
  logic                           fast_rdy    = 1'b1;
  logic                           sub_rdy     = 1'b1;
  clock_source_pkg::osc_enables_t osc_en;
  logic                           src_int;
  logic                           src_hs;
  logic [15:0]                    lfsr        = 16'h19ec;
  logic [7:0]                     opt;
  logic                           exp_wdt;
  int                             n_errors    = 0;
  int                             compares    = 0;
  int                             cyc         = 0;
  int                             gap;

  system_clock_source_control #(.SWITCH_GAP(GAP)) uut (
    .clk_sys_i            (clk_sys_i),
    .nrst_i               (nrst_i),
    .apb_req_i            (apb_req),
    .apb_rsp_o            (apb_rsp),
    .stop_mode_i          (stop_mode),
    .halt_mode_i          (halt_mode),
    .option_byte_i        (option_byte),
    .main_osc_ready_i     (main_rdy),
    .fast_int_osc_ready_i (fast_rdy),
    .sub_osc_ready_i      (sub_rdy),
    .osc_en_o             (osc_en),
    .cpu_src_int_o        (src_int),
    .cpu_src_hs_o         (src_hs)
  );

  always #25 clk_sys_i = ~clk_sys_i;

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      results();
    end
  end

  function automatic logic [15:0] rnd(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : rnd

  function automatic logic wdt_expect(input logic [7:0] ob, input logic h, input logic s);
    return ob[`CSRC_OPT_WDT_EN_BIT] & ~((h | s) & ~ob[`CSRC_OPT_STBY_RUN_BIT]);
  endfunction : wdt_expect

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : wait_cyc

  // One APB transfer; read data is compared only on reads
  task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wdata,
                      input logic [31:0] exp, input logic exp_err);
    @(posedge clk_sys_i);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wdata};
    @(posedge clk_sys_i);
    apb_req.penable <= 1'b1;
    do @(posedge clk_sys_i); while (apb_rsp.pready !== 1'b1);
    check({31'h0, apb_rsp.pslverr}, {31'h0, exp_err});
    if (!wr) check(apb_rsp.prdata, exp);
    apb_req.psel    <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask : xfer

  task automatic do_reset(input logic [7:0] ob);
    @(posedge clk_sys_i);
    nrst_i      <= 1'b0;
    stop_mode   <= 1'b0;
    halt_mode   <= 1'b0;
    option_byte <= ob;
    repeat (8) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    wait_cyc(3);
  endtask : do_reset

  task automatic results();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results

  // Both sources never claimed at once
  always @(negedge clk_sys_i) begin
    if (nrst_i && src_int === 1'b1 && src_hs === 1'b1) check(32'h1, 32'h0);
  end

  initial begin
    do_reset(8'h00);
    check({31'h0, src_int}, 32'h1);
    check({31'h0, src_hs}, 32'h0);
    check({26'h0, osc_en}, 32'h08);
    xfer(1'b0, `CSRC_OSC_CTRL_OFS, 32'h0, 32'hc0, 1'b0);
    xfer(1'b0, `CSRC_SYS_CLK_CTRL_OFS, 32'h0, 32'h00, 1'b0);
    xfer(1'b0, 12'h00c, 32'h0, 32'h0, 1'b1);
    lfsr = rnd(lfsr);
    xfer(1'b1, `CSRC_STATUS_OFS, {16'h0, lfsr}, 32'h0, 1'b0);
    // Select with main crystal stopped: the switch must wait
    xfer(1'b1, `CSRC_SYS_CLK_CTRL_OFS, 32'h10, 32'h0, 1'b0);
    wait_cyc(20);
    check({30'h0, src_int, src_hs}, 32'h2);
    lfsr = rnd(lfsr);
    xfer(1'b1, `CSRC_OSC_CTRL_OFS, {lfsr, 16'h0000}, 32'h0, 1'b0);
    xfer(1'b0, `CSRC_OSC_CTRL_OFS, 32'h0, 32'h00, 1'b0);
    check({31'h0, osc_en.main_osc_en}, 32'h1);
    check({31'h0, osc_en.sub_osc_en}, 32'h1);
    @(posedge clk_sys_i);
    main_rdy <= 1'b1;
    gap = 0;
    for (int i = 0; i < 40 && src_hs !== 1'b1; i++) begin
      wait_cyc(1);
      if (src_int === 1'b0 && src_hs === 1'b0) gap++;
    end
    check(gap, GAP);
    check({30'h0, src_int, src_hs}, 32'h1);
    xfer(1'b0, `CSRC_SYS_CLK_CTRL_OFS, 32'h0, 32'h30, 1'b0);
    lfsr = rnd(lfsr);
    xfer(1'b1, `CSRC_OSC_CTRL_OFS, {lfsr, 16'h0001}, 32'h0, 1'b0);
    xfer(1'b0, `CSRC_OSC_CTRL_OFS, 32'h0, 32'h01, 1'b0);
    check({31'h0, osc_en.fast_int_osc_en}, 32'h0);
    xfer(1'b1, `CSRC_OSC_CTRL_OFS, 32'h0, 32'h0, 1'b0);
    // Deselect once the internal clock runs again
    xfer(1'b1, `CSRC_SYS_CLK_CTRL_OFS, 32'h00, 32'h0, 1'b0);
    wait_cyc(GAP + 4);
    check({30'h0, src_int, src_hs}, 32'h2);
    xfer(1'b1, `CSRC_SYS_CLK_CTRL_OFS, 32'h50, 32'h0, 1'b0);
    wait_cyc(2);
    check({31'h0, osc_en.ext_clk_en}, 32'h1);
    wait_cyc(GAP + 2);
    check({30'h0, src_int, src_hs}, 32'h1);
    // STOP while running on the high-speed source
    @(posedge clk_sys_i);
    stop_mode <= 1'b1;
    wait_cyc(2);
    check({31'h0, osc_en.main_osc_en}, 32'h0);
    check({31'h0, osc_en.ext_clk_en}, 32'h0);
    check({31'h0, osc_en.fast_int_osc_en}, 32'h0);
    wait_cyc(GAP + 6);
    check({30'h0, src_int, src_hs}, 32'h2);
    @(posedge clk_sys_i);
    stop_mode <= 1'b0;
    xfer(1'b1, `CSRC_OSC_CTRL_OFS, 32'h80, 32'h0, 1'b0);
    wait_cyc(2);
    check({31'h0, osc_en.ext_clk_en}, 32'h0);
    xfer(1'b1, `CSRC_OSC_CTRL_OFS, 32'hc0, 32'h0, 1'b0);
    wait_cyc(2);
    check({31'h0, osc_en.sub_osc_en}, 32'h0);
    // Watchdog over option bytes, corners first, then random
    for (int i = 0; i < 10; i++) begin
      lfsr = rnd(lfsr);
      opt = (i < 4) ? {3'b000, i[1], 3'b000, i[0]} : lfsr[7:0];
      do_reset(opt);
      for (int m = 0; m < 4; m++) begin
        @(posedge clk_sys_i);
        halt_mode <= m[0];
        stop_mode <= m[1];
        wait_cyc(3);
        exp_wdt = wdt_expect(opt, m[0], m[1]);
        check({31'h0, osc_en.watchdog_run}, {31'h0, exp_wdt});
        check({31'h0, osc_en.low_speed_osc_en}, {31'h0, exp_wdt});
        check({30'h0, src_int, src_hs}, 32'h2);
      end
    end
    results();
  end
endmodule : tb_system_clock_source_control
